/* include/pef_map.vh */
// Purpose: constants for the port e / port f gpio block
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef PEF_MAP_VH
`define PEF_MAP_VH

// register indices, byte address = index * 4
`define PEF_IDX_E_LATCH   4'h8
`define PEF_IDX_F_LATCH   4'h9
`define PEF_IDX_E_DIR     4'hc
`define PEF_IDX_F_DIR     4'hd

// address bits that carry the index
`define PEF_IDX_HI        5
`define PEF_IDX_LO        2

// reset values of direction bits (all inputs)
`define PEF_E_DIR_RST     8'h00
`define PEF_F_DIR_RST     4'h0

// port e bit positions of shared functions
`define PEF_E_SCK         7
`define PEF_E_MOSI        6
`define PEF_E_MISO        5
`define PEF_E_SS          4
`define PEF_E_TCH1        3
`define PEF_E_TCH0        2
`define PEF_E_RXD         1
`define PEF_E_TXD         0

// edge/level select fields, two bits per timer channel
`define PEF_ELS_W         2
`define PEF_ELS_OFF       2'h0

// axi responses
`define PEF_RESP_OKAY     2'h0
`define PEF_RESP_SLVERR   2'h2

`endif

/* src/pef_gpio.v */
// Purpose: port e (8 bit) and port f (4 bit) gpio with pin sharing
// Assumes: spi, timer and serial unit live outside; only their
//          enables, selects and pin drive values arrive here
// Notes:   registers reached over axi4-lite, one 32-bit word each
`timescale 1ns/10ps
`include "pef_map.vh"

module pef_gpio #(
  parameter ADDR_W = 8,
  parameter E_W    = 8,
  parameter F_W    = 4,
  parameter TCH_N  = 6
) (
  // clock and reset
  input  wire                     aclk,
  input  wire                     aresetn,
  // axi4-lite write address
  input  wire [ADDR_W-1:0]        s_axi_awaddr,
  input  wire [2:0]               s_axi_awprot,
  input  wire                     s_axi_awvalid,
  output wire                     s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output wire                     s_axi_wready,
  // axi4-lite write response
  output wire [1:0]               s_axi_bresp,
  output wire                     s_axi_bvalid,
  input  wire                     s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0]        s_axi_araddr,
  input  wire [2:0]               s_axi_arprot,
  input  wire                     s_axi_arvalid,
  output wire                     s_axi_arready,
  // axi4-lite read data
  output wire [31:0]              s_axi_rdata,
  output wire [1:0]               s_axi_rresp,
  output wire                     s_axi_rvalid,
  input  wire                     s_axi_rready,
  // spi controls and drive values
  input  wire                     spi_enable_bit,
  input  wire                     spi_master_select,
  input  wire                     mode_fault_enable,
  input  wire                     spi_clock_out,
  input  wire                     spi_mosi_out,
  input  wire                     spi_miso_out,
  // serial unit controls and drive value
  input  wire                     serial_enable_bit,
  input  wire                     serial_txd_out,
  // timer channel selects and drive values
  input  wire [TCH_N*2-1:0]       edge_level_select,
  input  wire [TCH_N-1:0]         counter_channel_out,
  input  wire [TCH_N-1:0]         counter_channel_oe,
  // port e pins
  input  wire [E_W-1:0]           port_e_pin_i,
  output wire [E_W-1:0]           port_e_pin_o,
  output wire [E_W-1:0]           port_e_pin_oe,
  // port f pins
  input  wire [F_W-1:0]           port_f_pin_i,
  output wire [F_W-1:0]           port_f_pin_o,
  output wire [F_W-1:0]           port_f_pin_oe,
  // synchronised pin levels for the peripherals
  output wire [E_W-1:0]           port_e_level,
  output wire [F_W-1:0]           port_f_level
);

  // register state
  reg  [E_W-1:0]    port_e_latch_q;
  reg  [F_W-1:0]    port_f_latch_q;
  reg  [E_W-1:0]    port_e_direction_q;
  reg  [F_W-1:0]    port_f_direction_q;

  // pin synchronisers
  reg  [E_W-1:0]    e_meta_q;
  reg  [E_W-1:0]    e_sync_q;
  reg  [F_W-1:0]    f_meta_q;
  reg  [F_W-1:0]    f_sync_q;

  // registered pin drive
  reg  [E_W-1:0]    e_o_q;
  reg  [E_W-1:0]    e_oe_q;
  reg  [F_W-1:0]    f_o_q;
  reg  [F_W-1:0]    f_oe_q;
  reg  [E_W-1:0]    e_o_d;
  reg  [E_W-1:0]    e_oe_d;
  wire [F_W-1:0]    f_o_d;
  wire [F_W-1:0]    f_oe_d;

  // bus slave state
  reg               awready_q;
  reg               wready_q;
  reg               bvalid_q;
  reg  [1:0]        bresp_q;
  reg               arready_q;
  reg               rvalid_q;
  reg  [1:0]        rresp_q;
  reg  [31:0]       rdata_q;
  reg  [ADDR_W-1:0] waddr_q;
  reg  [31:0]       wdata_q;
  reg  [3:0]        wstrb_q;

  // decode helpers
  wire [3:0]        widx;
  wire [3:0]        ridx;
  wire              wfire;
  wire              wmapped;
  wire              rmapped;
  wire [E_W-1:0]    e_read;
  wire [F_W-1:0]    f_read;
  reg  [31:0]       rdata_d;

  // peripheral ownership
  wire              sck_own;
  wire              ss_own;
  wire [TCH_N-1:0]  tch_own;

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign port_e_pin_o  = e_o_q;
  assign port_e_pin_oe = e_oe_q;
  assign port_f_pin_o  = f_o_q;
  assign port_f_pin_oe = f_oe_q;
  assign port_e_level  = e_sync_q;
  assign port_f_level  = f_sync_q;

  // two-stage pin synchronisers
  always @(posedge aclk)
  begin
    e_meta_q <= port_e_pin_i;
    e_sync_q <= e_meta_q;
    f_meta_q <= port_f_pin_i;
    f_sync_q <= f_meta_q;
  end

  // timer channel ownership from edge/level select
  genvar g;
  generate
    for (g = 0; g < TCH_N; g = g + 1)
    begin : g_tch
      assign tch_own[g] =
        edge_level_select[g*`PEF_ELS_W +: `PEF_ELS_W] != `PEF_ELS_OFF;
    end
  endgenerate

  assign sck_own = spi_enable_bit;
  assign ss_own  = spi_enable_bit &
                   ~(spi_master_select & ~mode_fault_enable);

  // port e pin drive
  always @*
  begin
    e_o_d  = port_e_latch_q;
    e_oe_d = port_e_direction_q;
    if (sck_own)
    begin
      e_o_d[`PEF_E_SCK]  = spi_clock_out;
      e_oe_d[`PEF_E_SCK] = spi_master_select;
    end
    if (spi_enable_bit)
    begin
      e_o_d[`PEF_E_MOSI]  = spi_mosi_out;
      e_oe_d[`PEF_E_MOSI] = spi_master_select;
    end
    if (spi_enable_bit)
    begin
      e_o_d[`PEF_E_MISO]  = spi_miso_out;
      e_oe_d[`PEF_E_MISO] = ~spi_master_select;
    end
    if (ss_own)
    begin
      e_o_d[`PEF_E_SS]  = 1'b0;
      e_oe_d[`PEF_E_SS] = 1'b0;
    end
    if (tch_own[1])
    begin
      e_o_d[`PEF_E_TCH1]  = counter_channel_out[1];
      e_oe_d[`PEF_E_TCH1] = counter_channel_oe[1];
    end
    if (tch_own[0])
    begin
      e_o_d[`PEF_E_TCH0]  = counter_channel_out[0];
      e_oe_d[`PEF_E_TCH0] = counter_channel_oe[0];
    end
    if (serial_enable_bit)
    begin
      e_o_d[`PEF_E_RXD]  = 1'b0;
      e_oe_d[`PEF_E_RXD] = 1'b0;
    end
    if (serial_enable_bit)
    begin
      e_o_d[`PEF_E_TXD]  = serial_txd_out;
      e_oe_d[`PEF_E_TXD] = 1'b1;
    end
  end

  // port f pin drive, bit k is timer channel k+2
  generate
    for (g = 0; g < F_W; g = g + 1)
    begin : g_pf
      assign f_o_d[g]  = tch_own[g+2] ? counter_channel_out[g+2]
                                      : port_f_latch_q[g];
      assign f_oe_d[g] = tch_own[g+2] ? counter_channel_oe[g+2]
                                      : port_f_direction_q[g];
    end
  endgenerate

  // registered pin drive, floats during reset
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      e_o_q  <= {E_W{1'b0}};
      e_oe_q <= {E_W{1'b0}};
      f_o_q  <= {F_W{1'b0}};
      f_oe_q <= {F_W{1'b0}};
    end
    else
    begin
      e_o_q  <= e_o_d;
      e_oe_q <= e_oe_d;
      f_o_q  <= f_o_d;
      f_oe_q <= f_oe_d;
    end
  end

  // read values per bit
  // latch or pin by direction
  assign e_read = (port_e_direction_q & port_e_latch_q) |
                  (~port_e_direction_q & e_sync_q);
  assign f_read = (port_f_direction_q & port_f_latch_q) |
                  (~port_f_direction_q & f_sync_q);

  // address decode
  assign widx  = waddr_q[`PEF_IDX_HI:`PEF_IDX_LO];
  assign ridx  = s_axi_araddr[`PEF_IDX_HI:`PEF_IDX_LO];
  assign wmapped = (waddr_q[ADDR_W-1:`PEF_IDX_HI+1] == 0) &&
                   ((widx == `PEF_IDX_E_LATCH) ||
                    (widx == `PEF_IDX_F_LATCH) ||
                    (widx == `PEF_IDX_E_DIR) ||
                    (widx == `PEF_IDX_F_DIR));
  assign rmapped = (s_axi_araddr[ADDR_W-1:`PEF_IDX_HI+1] == 0) &&
                   ((ridx == `PEF_IDX_E_LATCH) ||
                    (ridx == `PEF_IDX_F_LATCH) ||
                    (ridx == `PEF_IDX_E_DIR) ||
                    (ridx == `PEF_IDX_F_DIR));
  assign wfire = ~awready_q & ~wready_q & ~bvalid_q;

  always @*
  begin
    rdata_d = 32'h0000_0000;
    case (ridx)
      `PEF_IDX_E_LATCH: rdata_d[E_W-1:0] = e_read;
      `PEF_IDX_F_LATCH: rdata_d[F_W-1:0] = f_read;
      `PEF_IDX_E_DIR:   rdata_d[E_W-1:0] = port_e_direction_q;
      `PEF_IDX_F_DIR:   rdata_d[F_W-1:0] = port_f_direction_q;
      default:          rdata_d = 32'h0000_0000;
    endcase
    if (!rmapped)
      rdata_d = 32'h0000_0000;
  end

  // write channels: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PEF_RESP_OKAY;
      waddr_q   <= {ADDR_W{1'b0}};
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        waddr_q   <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wfire)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wmapped ? `PEF_RESP_OKAY : `PEF_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // register writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_e_direction_q <= `PEF_E_DIR_RST;
      port_f_direction_q <= `PEF_F_DIR_RST;
    end
    else if (wfire && wstrb_q[0])
    begin
      if (widx == `PEF_IDX_E_DIR && wmapped)
        port_e_direction_q <= wdata_q[E_W-1:0];
      if (widx == `PEF_IDX_F_DIR && wmapped)
        port_f_direction_q <= wdata_q[F_W-1:0];
    end
  end

  always @(posedge aclk)
  begin
    if (wfire && wstrb_q[0] && wmapped)
    begin
      if (widx == `PEF_IDX_E_LATCH)
        port_e_latch_q <= wdata_q[E_W-1:0];
      if (widx == `PEF_IDX_F_LATCH)
        port_f_latch_q <= wdata_q[F_W-1:0];
    end
  end

  // read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `PEF_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_arvalid && arready_q)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rdata_d;
        rresp_q   <= rmapped ? `PEF_RESP_OKAY : `PEF_RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

endmodule // pef_gpio

/* bench/pef_pins.sv */
// Purpose: board side of the port pins
// Assumes: device drive wins over the board
// Notes:   undriven lines toggle every cycle
`timescale 1ns/10ps
module pef_pins #(parameter W = 8) (
  // clock
  input  wire logic         aclk,
  // device side
  input  wire logic [W-1:0] pin_o,
  input  wire logic [W-1:0] pin_oe,
  // board side
  input  wire logic [W-1:0] board_v,
  input  wire logic [W-1:0] board_en,
  output logic      [W-1:0] pin_i
);
  logic [W-1:0] float_q = '0;
  always @(posedge aclk)
    float_q <= ~float_q;
  // floating line never holds its last level
  always_comb
    for (int i = 0; i < W; i++)
      pin_i[i] = pin_oe[i] ? pin_o[i] : board_en[i] ? board_v[i] : float_q[i];
endmodule // pef_pins

/* bench/pef_gpio_chk.sv */
// Purpose: port timing checks for pef_gpio
// Assumes: one clock, sync active-low reset
// Notes:   bound into every pef_gpio
`timescale 1ns/10ps
module pef_gpio_chk #(parameter E_W = 8, F_W = 4, TCH_N = 6) (
  input wire logic aclk, aresetn,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid,
  input wire logic s_axi_arready, s_axi_rvalid,
  input wire logic spi_enable_bit, spi_master_select, mode_fault_enable,
  input wire logic spi_clock_out, spi_miso_out,
  input wire logic serial_enable_bit, serial_txd_out,
  input wire logic [TCH_N*2-1:0] edge_level_select,
  input wire logic [TCH_N-1:0] counter_channel_out, counter_channel_oe,
  input wire logic [E_W-1:0] port_e_pin_o, port_e_pin_oe,
  input wire logic [F_W-1:0] port_f_pin_o, port_f_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  wr_answer_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer off");
  reset_idle_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> port_e_pin_oe == 0 && port_f_pin_oe == 0)
    else $error("pins driven in reset");
  sck_dir_a: assert property (spi_enable_bit |=> port_e_pin_oe[7] ==
    $past(spi_master_select) && (!port_e_pin_oe[7] ||
    port_e_pin_o[7] == $past(spi_clock_out))) else $error("clock pin wrong");
  miso_dir_a: assert property (spi_enable_bit |=> port_e_pin_oe[5] ==
    !$past(spi_master_select) && (!port_e_pin_oe[5] ||
    port_e_pin_o[5] == $past(spi_miso_out))) else $error("miso pin wrong");
  ss_in_a: assert property (spi_enable_bit &&
    !(spi_master_select && !mode_fault_enable) |=> !port_e_pin_oe[4])
    else $error("select pin driven");
  txd_drive_a: assert property (serial_enable_bit |=> port_e_pin_oe[0] &&
    port_e_pin_o[0] == $past(serial_txd_out)) else $error("txd pin wrong");
  rxd_in_a: assert property (serial_enable_bit |=> !port_e_pin_oe[1])
    else $error("rxd pin driven");
  tch_e_a: assert property (edge_level_select[1:0] != 0 |=>
    port_e_pin_oe[2] == $past(counter_channel_oe[0]))
    else $error("channel 0 pin wrong");
  tch_f_a: assert property (edge_level_select[11:10] != 0 |=>
    port_f_pin_oe[3] == $past(counter_channel_oe[5]) && (!port_f_pin_oe[3]
    || port_f_pin_o[3] == $past(counter_channel_out[5])))
    else $error("channel 5 pin wrong");
endmodule // pef_gpio_chk
bind pef_gpio pef_gpio_chk #(.E_W(E_W), .F_W(F_W), .TCH_N(TCH_N)) chk_u (.*);

/* bench/pef_gpio_tb.sv */
// Purpose: self-checking bench for pef_gpio
// Assumes: board model on both ports
// Notes:   random ownership, latches and directions
`timescale 1ns/10ps
`include "pef_map.vh"
module pef_gpio_tb;
  localparam logic [7:0] AEL = {2'b00, `PEF_IDX_E_LATCH, 2'b00};
  localparam logic [7:0] AFL = {2'b00, `PEF_IDX_F_LATCH, 2'b00};
  localparam logic [7:0] AED = {2'b00, `PEF_IDX_E_DIR, 2'b00};
  localparam logic [7:0] AFD = {2'b00, `PEF_IDX_F_DIR, 2'b00};
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic bready = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, v, d;
  logic [3:0] wstrb = 0, s;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic spi_en = 0, mst = 0, mfe = 0, sck = 0, mosi = 0, miso = 0;
  logic ser_en = 0, txd = 0;
  logic [11:0] els = 0;
  logic [5:0] cch_o = 0, cch_oe = 0;
  logic [7:0] bv_e = 0, be_e = 0, lat_e, dir_e;
  logic [3:0] bv_f = 0, be_f = 0, lat_f, dir_f;
  wire [7:0] e_i, e_o, e_oe, lvl_e;
  wire [3:0] f_i, f_o, f_oe, lvl_f;
  int miscompares = 0, checks_done = 0;
  always #4 aclk = ~aclk;
  pef_gpio dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .spi_enable_bit(spi_en), .spi_master_select(mst),
    .mode_fault_enable(mfe), .spi_clock_out(sck), .spi_mosi_out(mosi),
    .spi_miso_out(miso), .serial_enable_bit(ser_en), .serial_txd_out(txd),
    .edge_level_select(els), .counter_channel_out(cch_o),
    .counter_channel_oe(cch_oe), .port_e_pin_i(e_i), .port_e_pin_o(e_o),
    .port_e_pin_oe(e_oe), .port_f_pin_i(f_i), .port_f_pin_o(f_o),
    .port_f_pin_oe(f_oe), .port_e_level(lvl_e), .port_f_level(lvl_f));
  pef_pins #(.W(8)) pe_u (.aclk(aclk), .pin_o(e_o), .pin_oe(e_oe),
    .board_v(bv_e), .board_en(be_e), .pin_i(e_i));
  pef_pins #(.W(4)) pf_u (.aclk(aclk), .pin_o(f_o), .pin_oe(f_oe),
    .board_v(bv_f), .board_en(be_f), .pin_i(f_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat,
                    input logic [3:0] st, output logic [1:0] rsp);
    awaddr <= a; wdata <= dat; wstrb <= st; awvalid <= 1; wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat,
                    output logic [1:0] rsp);
    araddr <= a; arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    dat = rdata; rsp = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask
  // expected drive from ownership, then read value from pin level
  task automatic chk_port(input logic [7:0] w, poe, po, dir, lat, soe, so,
                          input logic [7:0] bv, be, rdv, lv);
    logic [7:0] eoe, eo, lvl, m;
    eoe = (w & poe) | (~w & dir);
    eo = (w & po) | (~w & lat);
    lvl = (eoe & eo) | (~eoe & bv);
    m = dir | eoe | be;
    chk(soe, eoe);
    chk(so & eoe, eo & eoe);
    chk(rdv & m, ((dir & lat) | (~dir & lvl)) & m);
    chk(lv & (eoe | be), lvl & (eoe | be));
  endtask
  function automatic logic [23:0] own_e();
    logic [7:0] w, oe, o;
    w = 0; oe = 0; o = 0;
    if (spi_en)
    begin
      w[7:5] = 3'b111; oe[7:5] = {mst, mst, !mst}; o[7:5] = {sck, mosi, miso};
      w[4] = !(mst && !mfe);
    end
    for (int k = 0; k < 2; k++)
      if (els[2*k+:2] != 0)
      begin
        w[2+k] = 1; oe[2+k] = cch_oe[k]; o[2+k] = cch_o[k];
      end
    if (ser_en)
    begin
      w[1:0] = 2'b11; oe[0] = 1; o[0] = txd;
    end
    return {w, oe, o};
  endfunction
  function automatic logic [11:0] own_f();
    logic [3:0] w, oe, o;
    for (int k = 0; k < 4; k++)
    begin
      w[k] = els[2*(k+2)+:2] != 0; oe[k] = cch_oe[k+2]; o[k] = cch_o[k+2];
    end
    return {w, oe, o};
  endfunction
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    give_verdict();
  end
  initial
  begin
    logic [23:0] oe8;
    logic [11:0] of4;
    void'($urandom(32'hfcf5));
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk({e_oe, f_oe}, 0);
    rd(AED, d, r); chk(d, 0);
    rd(AFD, d, r); chk(d, 0);
    for (int i = 0; i < 40; i++)
    begin
      s = (i == 0) ? 4'hf : 4'($urandom);
      {spi_en, mst, mfe, sck, mosi, miso, ser_en, txd} <= 8'($urandom);
      els <= 12'($urandom); {cch_o, cch_oe} <= 12'($urandom);
      {bv_e, be_e, bv_f, be_f} <= 24'($urandom);
      v = $urandom;
      wr(AEL, {24'h0, v[7:0]}, s, r); chk(r, `PEF_RESP_OKAY);
      wr(AFL, {28'h0, v[11:8]}, s, r); chk(r, `PEF_RESP_OKAY);
      if (s[0]) {lat_f, lat_e} = v[11:0];
      wr(AED, {24'h0, v[23:16]}, 4'hf, r); chk(r, `PEF_RESP_OKAY);
      wr(AFD, {28'h0, v[27:24]}, 4'hf, r); chk(r, `PEF_RESP_OKAY);
      {dir_f, dir_e} = {v[27:24], v[23:16]};
      repeat (4) @(posedge aclk);
      oe8 = own_e(); of4 = own_f();
      rd(AEL, d, r);
      chk_port(oe8[23:16], oe8[15:8], oe8[7:0], dir_e, lat_e, e_oe, e_o,
               bv_e, be_e, d[7:0], lvl_e);
      rd(AFL, d, r);
      chk_port({4'h0, of4[11:8]}, {4'h0, of4[7:4]}, {4'h0, of4[3:0]},
               {4'h0, dir_f}, {4'h0, lat_f}, {4'h0, f_oe}, {4'h0, f_o},
               {4'h0, bv_f}, {4'h0, be_f}, d[7:0],
               {4'h0, lvl_f});
    end
    wr(8'h28, 32'h5a, 4'hf, r); chk(r, `PEF_RESP_SLVERR);
    rd(8'h3c, d, r); chk({d, r}, {32'h0, `PEF_RESP_SLVERR});
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(AED, d, r); chk(d, 0);
    rd(AFD, d, r); chk(d, 0);
    wr(AED, 32'hff, 4'hf, r);
    wr(AFD, 32'hf, 4'hf, r);
    rd(AEL, d, r); chk(d, {24'h0, lat_e});
    rd(AFL, d, r); chk(d, {28'h0, lat_f});
    give_verdict();
  end
endmodule // pef_gpio_tb
